// *** core/chb_bus_if.sv ***
// Card socket link between host controller and card
`timescale 1ns/1ps
interface chb_bus_if;
  logic        attr_sel_n;
  logic        high_lane_select_n;
  logic        low_lane_select_n;
  logic [10:0] addr;
  logic        out_strobe_n;
  logic        write_strobe_n;
  logic        io_read_strobe_n;
  logic        io_write_strobe_n;
  logic        dma_ack_n;
  logic [15:0] host_dout;
  logic [1:0]  host_doe_n;
  logic [15:0] card_dout;
  logic [1:0]  card_doe_n;
  logic        card_ready;
  logic [15:0] data;

  // Pulled-up shared lanes, card driver first
  assign data[7:0]  = !card_doe_n[0] ? card_dout[7:0]
                    : (!host_doe_n[0] ? host_dout[7:0] : 8'hFF);
  assign data[15:8] = !card_doe_n[1] ? card_dout[15:8]
                    : (!host_doe_n[1] ? host_dout[15:8] : 8'hFF);

  modport card (
    input  attr_sel_n, high_lane_select_n, low_lane_select_n, addr,
    input  out_strobe_n, write_strobe_n, io_read_strobe_n,
    input  io_write_strobe_n, dma_ack_n, data,
    output card_dout, card_doe_n, card_ready
  );
  modport host (
    output attr_sel_n, high_lane_select_n, low_lane_select_n, addr,
    output out_strobe_n, write_strobe_n, io_read_strobe_n,
    output io_write_strobe_n, dma_ack_n, host_dout, host_doe_n,
    input  data, card_ready
  );
endinterface : chb_bus_if

// *** core/chb_card.sv ***
// Card end: access decoder, task file, config registers and data FIFO
//
// Overview of operation
// - Attribute decoded only with attribute select low
// - Attribute read drives even byte, low lane
// - Attribute write takes even byte, low lane
// - Writes to info structure are ignored
// - Task file via I/O or memory mapping
// - I/O task file read steers bytes by cycle
// - I/O task file write captures lanes by cycle
// - Memory task file read steers like I/O
// - Memory task file write captures like I/O
// - Output strobe low at power-on: disk mode
// - Disk mode refuses attribute space access
// - Disk mode data transfers default sixteen-bit
// - Set features selects eight-bit data transfers
// - Both chip selects low in disk mode: invalid, ignored
// - PIO data: low select, address zero
// - DMA data: selects high, acknowledge low
// - Alternate status read, device control write
// - Other task file registers use low lane in disk mode
// - Config registers unusable in disk mode
// - Host ties write strobe high in disk mode
// - Reset clears mode index to zero
`timescale 1ns/1ps
module chb_fifo #(
  parameter int W = 16,
  parameter int D = 16
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic [W-1:0]      out_data
);
  localparam int AW = $clog2(D);
  logic [W-1:0] mem [D];
  logic [AW-1:0] wp_reg;
  logic [AW-1:0] rp_reg;
  logic [AW:0]   cnt_reg;
  logic          push;
  logic          pop;

  assign in_ready  = cnt_reg != (AW+1)'(D);
  assign out_valid = cnt_reg != '0;
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;
  assign out_data  = mem[rp_reg];

  always_ff @(posedge clk) begin
    if (push) begin
      mem[wp_reg] <= in_data;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      wp_reg  <= '0;
      rp_reg  <= '0;
      cnt_reg <= '0;
    end else begin
      if (push) begin
        wp_reg <= (wp_reg == AW'(D-1)) ? '0 : wp_reg + 1'b1;
      end
      if (pop) begin
        rp_reg <= (rp_reg == AW'(D-1)) ? '0 : rp_reg + 1'b1;
      end
      cnt_reg <= cnt_reg + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule : chb_fifo

module chb_card #(
  parameter int DEPTH = 16
) (
  input  wire logic        clk,
  input  wire logic        rst_n,
  chb_bus_if.card          bus,
  output logic             rx_valid,
  input  wire logic        rx_ready,
  output logic [15:0]      rx_data,
  input  wire logic [15:0] tx_data,
  output logic             tx_ack,
  output logic             disk_mode,
  output logic             byte_mode
);
  localparam int SW = 35;
  logic [SW-1:0] s1_reg;
  logic [SW-1:0] s2_reg;
  logic p_attr_n, p_hsel_n, p_lsel_n, p_oe_n, p_we_n, p_io_read_strobe_n_n, p_io_write_strobe_n_n;
  logic p_dmack_n;
  logic [10:0] p_addr;
  logic [15:0] p_data;
  logic [7:0]  cfg_reg [4];
  logic [7:0]  tf_reg [8];
  logic [7:0]  ctl_reg;
  logic [7:0]  view [8];
  logic        disk_reg, byte_reg, rd_prev_reg, wr_prev_reg, tx_ack_reg;
  logic [15:0] dout_reg;
  logic [1:0]  doe_n_reg;
  logic        fifo_ready;
  logic [7:0]  status;
  // Decode results
  logic rd_act, wr_act, drv_lo, drv_hi, tf_go, hit, alt, data_hit;
  logic cfg_w, lo_w, hi_w, alt_w, push_en, data_rd;
  logic [15:0] rd_word;
  logic [2:0]  lo_idx, hi_idx;
  logic [1:0]  cyc;
  logic [1:0]  cfg_idx;
  logic rd_go, wr_go;

  function automatic logic [1:0] io_hit(input logic [5:0] idx,
                                        input logic [10:0] a);
    case (idx)
      chb_pkg::IDX_CONT: io_hit = {1'b1, a[3]};
      chb_pkg::IDX_PRI:  io_hit = (a[9:3] == chb_pkg::PRI_TF) ? 2'b10 :
                                  {a[9:1] == chb_pkg::PRI_ALT, 1'b1};
      chb_pkg::IDX_SEC:  io_hit = (a[9:3] == chb_pkg::SEC_TF) ? 2'b10 :
                                  {a[9:1] == chb_pkg::SEC_ALT, 1'b1};
      default:           io_hit = 2'b00;
    endcase
  endfunction : io_hit

  // Host pins arrive unclocked
  always_ff @(posedge clk) begin
    s1_reg <= {bus.attr_sel_n, bus.high_lane_select_n, bus.low_lane_select_n,
               bus.addr, bus.out_strobe_n, bus.write_strobe_n,
               bus.io_read_strobe_n, bus.io_write_strobe_n, bus.dma_ack_n,
               bus.data};
    s2_reg <= s1_reg;
  end
  assign {p_attr_n, p_hsel_n, p_lsel_n, p_addr, p_oe_n, p_we_n, p_io_read_strobe_n_n,
          p_io_write_strobe_n_n, p_dmack_n, p_data} = s2_reg;

  assign status = chb_pkg::STAT_IDLE
                | (8'(fifo_ready) << chb_pkg::STAT_DRQ_BIT);
  always_comb begin
    view[0] = tx_data[7:0];
    for (int i = 1; i < 7; i++) begin
      view[i] = tf_reg[i];
    end
    view[7] = status;
  end

  always_comb begin
    rd_act = 1'b0; wr_act = 1'b0; drv_lo = 1'b0; drv_hi = 1'b0;
    tf_go = 1'b0; hit = 1'b0; alt = 1'b0; data_hit = 1'b0;
    cfg_w = 1'b0; lo_w = 1'b0; hi_w = 1'b0; alt_w = 1'b0;
    push_en = 1'b0; data_rd = 1'b0;
    rd_word = {chb_pkg::INVALID_BYTE, chb_pkg::INVALID_BYTE};
    cfg_idx = p_addr[2:1];
    cyc = {!p_hsel_n, !p_lsel_n};
    lo_idx = (cyc == 2'b01) ? p_addr[2:0] : {p_addr[2:1], 1'b0};
    hi_idx = {p_addr[2:1], 1'b1};
    if (disk_reg) begin
      // Attribute select and config space are never consulted here
      rd_act = !p_io_read_strobe_n_n;
      wr_act = !p_io_write_strobe_n_n;
      if (!p_hsel_n && !p_lsel_n) begin
        rd_act = 1'b0;
        wr_act = 1'b0;
      end else if (!p_dmack_n && p_hsel_n && p_lsel_n) begin
        drv_lo = 1'b1;
        drv_hi = !byte_reg;
        rd_word = tx_data;
        push_en = 1'b1;
        data_rd = 1'b1;
      end else if (!p_dmack_n) begin
        rd_act = 1'b0;
        wr_act = 1'b0;
      end else if (!p_lsel_n && p_addr[2:0] == chb_pkg::TF_DATA) begin
        drv_lo = 1'b1;
        drv_hi = !byte_reg;
        rd_word = tx_data;
        push_en = 1'b1;
        data_rd = 1'b1;
      end else if (!p_lsel_n) begin
        drv_lo = 1'b1;
        rd_word[7:0] = view[p_addr[2:0]];
        lo_w = 1'b1;
        lo_idx = p_addr[2:0];
      end else if (!p_hsel_n && p_addr[2:0] == chb_pkg::TF_ALT) begin
        drv_lo = 1'b1;
        rd_word[7:0] = status;
        alt_w = 1'b1;
      end else begin
        rd_act = 1'b0;
        wr_act = 1'b0;
      end
    end else if (!p_attr_n && (!p_oe_n || !p_we_n)) begin
      rd_act = !p_oe_n;
      wr_act = !p_we_n;
      drv_lo = !p_lsel_n;
      drv_hi = !p_hsel_n;
      if (p_addr < chb_pkg::CFG_BASE) begin
        rd_word[7:0] = (p_addr[8:1] == '0) ? chb_pkg::CIS_FIRST
                                           : chb_pkg::CIS_FILL;
      end else if (p_addr[10:3] == chb_pkg::CFG_BLOCK) begin
        rd_word[7:0] = cfg_reg[cfg_idx];
        cfg_w = 1'b1;
      end
      if (cyc == 2'b01 && p_addr[0]) begin
        rd_word[7:0] = chb_pkg::INVALID_BYTE;
      end
      if (!(cyc == 2'b11 || (cyc == 2'b01 && !p_addr[0]))) begin
        cfg_w = 1'b0;
      end
    end else if (cfg_reg[0][5:0] != chb_pkg::IDX_MEM && !p_attr_n) begin
      rd_act = !p_io_read_strobe_n_n;
      wr_act = !p_io_write_strobe_n_n;
      {hit, alt} = io_hit(cfg_reg[0][5:0], p_addr);
      tf_go = 1'b1;
    end else if (cfg_reg[0][5:0] == chb_pkg::IDX_MEM && p_attr_n) begin
      rd_act = !p_oe_n;
      wr_act = !p_we_n;
      hit = p_addr[10:4] == '0 || p_addr[10];
      alt = p_addr[3];
      tf_go = 1'b1;
    end
    if (tf_go) begin
      if (!hit || cyc == 2'b00) begin
        rd_act = 1'b0;
        wr_act = 1'b0;
      end
      data_hit = (cyc == 2'b01 && p_addr[2:0] == chb_pkg::TF_DATA)
              || (cyc == 2'b11 && p_addr[2:1] == 2'b00);
      drv_lo = cyc[0];
      drv_hi = cyc[1];
      rd_word = {view[hi_idx], view[lo_idx]};
      if (alt && lo_idx == chb_pkg::TF_ALT) begin
        rd_word[7:0] = status;
      end
      if (data_hit) begin
        rd_word = (cyc == 2'b11) ? tx_data : {8'h00, tx_data[7:0]};
        push_en = 1'b1;
        data_rd = 1'b1;
      end else begin
        alt_w = cyc[0] && alt && lo_idx == chb_pkg::TF_ALT;
        lo_w = cyc[0] && !alt_w;
        hi_w = cyc[1];
      end
    end
  end

  assign rd_go = rd_act && !rd_prev_reg;
  assign wr_go = wr_act && !wr_prev_reg;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      // Strap seen through the synchroniser while reset is held
      // Output strobe sits twenty bits up the synchroniser word
      disk_reg <= !s2_reg[SW-15];
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rd_prev_reg <= 1'b0;
      wr_prev_reg <= 1'b0;
      tx_ack_reg  <= 1'b0;
      dout_reg    <= '0;
      doe_n_reg   <= 2'b11;
    end else begin
      rd_prev_reg <= rd_act;
      wr_prev_reg <= wr_act;
      tx_ack_reg  <= rd_go && data_rd;
      dout_reg    <= rd_word;
      doe_n_reg   <= rd_act ? {!drv_hi, !drv_lo} : 2'b11;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cfg_reg[0] <= chb_pkg::CFG_OPT_RST;
      cfg_reg[1] <= chb_pkg::CFG_STAT_RST;
      cfg_reg[2] <= chb_pkg::CFG_PIN_RST;
      cfg_reg[3] <= chb_pkg::CFG_SOCK_RST;
    end else if (wr_go && cfg_w) begin
      case (cfg_idx)
        2'd0: cfg_reg[0] <= p_data[7:0] & chb_pkg::CFG_OPT_MASK;
        2'd1: cfg_reg[1] <= p_data[7:0] & chb_pkg::CFG_STAT_MASK;
        2'd2: cfg_reg[2] <= (p_data[7:0] & chb_pkg::CFG_PIN_MASK)
                          | chb_pkg::CFG_PIN_RST;
        default: cfg_reg[3] <= p_data[7:0] & chb_pkg::CFG_SOCK_MASK;
      endcase
    end
  end

  // Soft reset bit holds the task file cleared while set
  always_ff @(posedge clk) begin
    if (!rst_n || cfg_reg[0][chb_pkg::OPT_SRESET_BIT]) begin
      tf_reg   <= '{default: chb_pkg::TF_RST};
      ctl_reg  <= chb_pkg::CTL_RST;
      byte_reg <= 1'b0;
    end else if (wr_go) begin
      if (lo_w) begin
        tf_reg[lo_idx] <= p_data[7:0];
      end
      if (hi_w) begin
        tf_reg[hi_idx] <= p_data[15:8];
      end
      if (alt_w) begin
        ctl_reg <= p_data[7:0];
      end
      if (lo_w && lo_idx == chb_pkg::TF_CMD
          && p_data[7:0] == chb_pkg::CMD_SET_FEAT) begin
        if (tf_reg[chb_pkg::TF_FEAT] == chb_pkg::FEAT_8BIT_ON) begin
          byte_reg <= 1'b1;
        end else if (tf_reg[chb_pkg::TF_FEAT] == chb_pkg::FEAT_8BIT_OFF) begin
          byte_reg <= 1'b0;
        end
      end
    end
  end

  // Full FIFO drops the word; host must watch card_ready first
  chb_fifo #(.W(16), .D(DEPTH)) u_fifo (
    .clk       (clk),
    .rst_n     (rst_n),
    .in_valid  (wr_go && push_en),
    .in_ready  (fifo_ready),
    .in_data   ((disk_reg && !byte_reg) || cyc == 2'b11 ? p_data
                                                        : {8'h00, p_data[7:0]}),
    .out_valid (rx_valid),
    .out_ready (rx_ready),
    .out_data  (rx_data)
  );

  assign bus.card_dout  = dout_reg;
  assign bus.card_doe_n = doe_n_reg;
  assign bus.card_ready = fifo_ready;
  assign tx_ack         = tx_ack_reg;
  assign disk_mode      = disk_reg;
  assign byte_mode      = byte_reg;
endmodule : chb_card

// *** core/chb_host.sv ***
// Host end: sequences one socket cycle per user command
`timescale 1ns/1ps
module chb_host (
  input  wire logic        clk,
  input  wire logic        rst_n,
  chb_bus_if.host          bus,
  input  wire logic        disk_req,
  input  wire logic        cmd_valid,
  output logic             cmd_ready,
  input  wire logic [2:0]  cmd_space,
  input  wire logic [1:0]  cmd_width,
  input  wire logic        cmd_write,
  input  wire logic [10:0] cmd_addr,
  input  wire logic [15:0] cmd_wdata,
  output logic             rsp_valid,
  output logic [15:0]      rsp_data,
  output logic             disk_mode
);
  chb_pkg::chb_state_e state_reg;
  logic [7:0]  cnt_reg;
  logic [16:0] s1_reg;
  logic [16:0] s2_reg;
  logic        disk_reg, rsp_reg;
  logic [15:0] rsp_data_reg;
  logic [2:0]  sp_reg;
  logic [1:0]  w_reg;
  logic        wr_reg;
  logic        attr_n_reg, hsel_n_reg, lsel_n_reg, dmack_n_reg;
  logic        oe_n_reg, we_n_reg, io_read_strobe_n_n_reg, io_write_strobe_n_n_reg;
  logic [10:0] addr_reg;
  logic [15:0] dout_reg;
  logic [1:0]  doe_n_reg;
  logic        strobe_on;

  always_ff @(posedge clk) begin
    s1_reg <= {bus.card_ready, bus.data};
    s2_reg <= s1_reg;
  end

  assign cmd_ready = state_reg == chb_pkg::CHB_IDLE && s2_reg[16];
  assign strobe_on = state_reg == chb_pkg::CHB_STROBE;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      disk_reg <= disk_req;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state_reg    <= chb_pkg::CHB_IDLE;
      cnt_reg      <= '0;
      rsp_reg      <= 1'b0;
      rsp_data_reg <= '0;
      sp_reg       <= '0;
      w_reg        <= '0;
      wr_reg       <= 1'b0;
      addr_reg     <= '0;
      dout_reg     <= '0;
    end else begin
      rsp_reg <= 1'b0;
      case (state_reg)
        chb_pkg::CHB_IDLE: begin
          if (cmd_valid && cmd_ready) begin
            sp_reg    <= cmd_space;
            w_reg     <= cmd_width;
            wr_reg    <= cmd_write;
            addr_reg  <= cmd_addr;
            dout_reg  <= cmd_wdata;
            cnt_reg   <= 8'(chb_pkg::SETUP_CYC - 1);
            state_reg <= chb_pkg::CHB_SETUP;
          end
        end
        chb_pkg::CHB_SETUP: begin
          cnt_reg <= cnt_reg - 1'b1;
          if (cnt_reg == '0) begin
            cnt_reg   <= 8'(chb_pkg::STROBE_CYC - 1);
            state_reg <= chb_pkg::CHB_STROBE;
          end
        end
        chb_pkg::CHB_STROBE: begin
          cnt_reg <= cnt_reg - 1'b1;
          if (cnt_reg == '0) begin
            rsp_data_reg <= s2_reg[15:0];
            rsp_reg      <= 1'b1;
            cnt_reg      <= 8'(chb_pkg::HOLD_CYC - 1);
            state_reg    <= chb_pkg::CHB_HOLD;
          end
        end
        chb_pkg::CHB_HOLD: begin
          cnt_reg <= cnt_reg - 1'b1;
          if (cnt_reg == '0) begin
            state_reg <= chb_pkg::CHB_IDLE;
          end
        end
        default: state_reg <= chb_pkg::CHB_IDLE;
      endcase
    end
  end

  // Pin drive derived from the latched command
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      attr_n_reg  <= 1'b1;
      hsel_n_reg  <= 1'b1;
      lsel_n_reg  <= 1'b1;
      dmack_n_reg <= 1'b1;
      oe_n_reg    <= !disk_req;
      we_n_reg    <= 1'b1;
      io_read_strobe_n_n_reg  <= 1'b1;
      io_write_strobe_n_n_reg  <= 1'b1;
      doe_n_reg   <= 2'b11;
    end else begin
      oe_n_reg   <= 1'b1;
      we_n_reg   <= 1'b1;
      io_read_strobe_n_n_reg <= 1'b1;
      io_write_strobe_n_n_reg <= 1'b1;
      if (state_reg == chb_pkg::CHB_IDLE) begin
        attr_n_reg  <= 1'b1;
        hsel_n_reg  <= 1'b1;
        lsel_n_reg  <= 1'b1;
        dmack_n_reg <= 1'b1;
        doe_n_reg   <= 2'b11;
      end else begin
        doe_n_reg <= wr_reg ? 2'b00 : 2'b11;
        case (sp_reg)
          3'(chb_pkg::CHB_SP_PIO): begin
            hsel_n_reg <= !addr_reg[3];
            lsel_n_reg <= addr_reg[3];
          end
          3'(chb_pkg::CHB_SP_DMA): begin
            dmack_n_reg <= 1'b0;
          end
          default: begin
            attr_n_reg <= sp_reg == 3'(chb_pkg::CHB_SP_MEM);
            hsel_n_reg <= w_reg == 2'(chb_pkg::CHB_W_BYTE);
            lsel_n_reg <= w_reg == 2'(chb_pkg::CHB_W_ODD);
          end
        endcase
        if (strobe_on && cnt_reg != '0) begin
          if (sp_reg >= 3'(chb_pkg::CHB_SP_IO)) begin
            io_read_strobe_n_n_reg <= wr_reg;
            io_write_strobe_n_n_reg <= !wr_reg;
          end else begin
            oe_n_reg <= wr_reg;
            we_n_reg <= !wr_reg || disk_reg;
          end
        end
      end
    end
  end

  assign bus.attr_sel_n         = attr_n_reg;
  assign bus.high_lane_select_n = hsel_n_reg;
  assign bus.low_lane_select_n  = lsel_n_reg;
  assign bus.addr               = addr_reg;
  assign bus.out_strobe_n       = oe_n_reg;
  assign bus.write_strobe_n     = we_n_reg;
  assign bus.io_read_strobe_n   = io_read_strobe_n_n_reg;
  assign bus.io_write_strobe_n  = io_write_strobe_n_n_reg;
  assign bus.dma_ack_n          = dmack_n_reg;
  assign bus.host_dout          = dout_reg;
  assign bus.host_doe_n         = doe_n_reg;
  assign rsp_valid              = rsp_reg;
  assign rsp_data               = rsp_data_reg;
  assign disk_mode              = disk_reg;
endmodule : chb_host

// *** core/chb_pkg.sv ***
// Shared constants and types for the card host bus access decoder
package chb_pkg;
  localparam int ADDR_W    = 11;
  localparam int CLK_NS    = 20;
  localparam int SETUP_NS  = 40;
  localparam int STROBE_NS = 160;
  localparam int HOLD_NS   = 40;
  localparam int SETUP_CYC  = (SETUP_NS + CLK_NS - 1) / CLK_NS;
  localparam int STROBE_CYC = (STROBE_NS + CLK_NS - 1) / CLK_NS;
  localparam int HOLD_CYC   = (HOLD_NS + CLK_NS - 1) / CLK_NS;
  // Attribute space
  localparam logic [10:0] CFG_BASE   = 11'h0200;
  localparam logic [7:0]  CFG_BLOCK  = 8'h40;
  localparam logic [7:0]  CIS_FIRST  = 8'h01;
  localparam logic [7:0]  CIS_FILL   = 8'hFF;
  localparam logic [7:0]  CFG_OPT_RST  = 8'h00;
  localparam logic [7:0]  CFG_STAT_RST = 8'h00;
  localparam logic [7:0]  CFG_PIN_RST  = 8'h0C;
  localparam logic [7:0]  CFG_SOCK_RST = 8'h00;
  localparam logic [7:0]  CFG_OPT_MASK  = 8'hFF;
  localparam logic [7:0]  CFG_STAT_MASK = 8'h64;
  localparam logic [7:0]  CFG_PIN_MASK  = 8'h20;
  localparam logic [7:0]  CFG_SOCK_MASK = 8'h10;
  localparam int          OPT_SRESET_BIT = 7;
  localparam logic [5:0]  IDX_MEM  = 6'h00;
  localparam logic [5:0]  IDX_CONT = 6'h01;
  localparam logic [5:0]  IDX_PRI  = 6'h02;
  localparam logic [5:0]  IDX_SEC  = 6'h03;
  // I/O windows, base >> 3 for registers and >> 1 for the alternate pair
  localparam logic [6:0]  PRI_TF   = 7'h3E;
  localparam logic [8:0]  PRI_ALT  = 9'h1FB;
  localparam logic [6:0]  SEC_TF   = 7'h2E;
  localparam logic [8:0]  SEC_ALT  = 9'h1BB;
  // Task file
  localparam logic [2:0]  TF_DATA  = 3'h0;
  localparam logic [2:0]  TF_FEAT  = 3'h1;
  localparam logic [2:0]  TF_ALT   = 3'h6;
  localparam logic [2:0]  TF_CMD   = 3'h7;
  localparam logic [7:0]  TF_RST   = 8'h00;
  localparam logic [7:0]  CTL_RST  = 8'h00;
  localparam logic [7:0]  STAT_IDLE = 8'h50;
  localparam int          STAT_DRQ_BIT = 3;
  localparam logic [7:0]  CMD_SET_FEAT = 8'hEF;
  localparam logic [7:0]  FEAT_8BIT_ON  = 8'h01;
  localparam logic [7:0]  FEAT_8BIT_OFF = 8'h81;
  localparam logic [7:0]  INVALID_BYTE  = 8'hFF;

  typedef enum logic [2:0] {
    CHB_SP_ATTR = 3'h0,
    CHB_SP_MEM  = 3'h1,
    CHB_SP_IO   = 3'h2,
    CHB_SP_PIO  = 3'h3,
    CHB_SP_DMA  = 3'h4
  } chb_space_e;

  typedef enum logic [1:0] {
    CHB_W_BYTE = 2'h0,
    CHB_W_WORD = 2'h1,
    CHB_W_ODD  = 2'h2
  } chb_width_e;

  typedef enum logic [1:0] {
    CHB_IDLE   = 2'b00,
    CHB_SETUP  = 2'b01,
    CHB_STROBE = 2'b11,
    CHB_HOLD   = 2'b10
  } chb_state_e;
endpackage : chb_pkg

// *** verif/card_host_bus_access_decoder_bench.sv ***
// Bench: host end drives card end across the socket link
`timescale 1ns/1ps
module card_host_bus_access_decoder_bench;
  logic        clk, rst_n, disk_req, cmd_valid, cmd_ready, cmd_write;
  logic        rsp_valid, h_disk, c_disk, byte_mode, rx_valid, rx_ready;
  logic [2:0]  cmd_space;
  logic [1:0]  cmd_width;
  logic [10:0] cmd_addr;
  logic [15:0] cmd_wdata, rsp_data, rx_data, tx_data;
  logic        tx_ack;
  int          n_fail, checked, i, n_ack;

  chb_bus_if bus ();
  chb_host chb_host_inst (.clk, .rst_n, .bus(bus.host), .disk_req,
    .cmd_valid, .cmd_ready, .cmd_space, .cmd_width, .cmd_write, .cmd_addr,
    .cmd_wdata, .rsp_valid, .rsp_data, .disk_mode(h_disk));
  chb_card #(.DEPTH(16)) chb_card_inst (.clk, .rst_n, .bus(bus.card),
    .rx_valid, .rx_ready, .rx_data, .tx_data, .tx_ack,
    .disk_mode(c_disk), .byte_mode);
  chb_sva chb_sva_inst (.clk, .rst_n, .attr_sel_n(bus.attr_sel_n),
    .high_lane_select_n(bus.high_lane_select_n),
    .low_lane_select_n(bus.low_lane_select_n), .addr(bus.addr),
    .out_strobe_n(bus.out_strobe_n), .write_strobe_n(bus.write_strobe_n),
    .io_read_strobe_n(bus.io_read_strobe_n),
    .io_write_strobe_n(bus.io_write_strobe_n), .dma_ack_n(bus.dma_ack_n),
    .card_dout(bus.card_dout), .card_doe_n(bus.card_doe_n));

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  // Data register read starts reported by the card
  always @(posedge clk) begin
    if (tx_ack === 1'b1) n_ack++;
  end

  task automatic wrap_up;
    $display("checked %0d n_fail %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : wrap_up

  task automatic chk16(input logic [15:0] g, input logic [15:0] e);
    checked++;
    if (g !== e) begin
      n_fail++;
      $display("mismatch at %0t: data %h, want %h", $time, g, e);
    end
  endtask : chk16

  task automatic chk1(input logic g, input logic e);
    checked++;
    if (g !== e) begin
      n_fail++;
      $display("mismatch at %0t: flag %b, want %b", $time, g, e);
    end
  endtask : chk1

  // One socket cycle; for reads d is the expected response
  task automatic t(input logic [2:0] sp, input logic [1:0] w,
                   input logic wr, input logic [10:0] a,
                   input logic [15:0] d);
    int k;
    k = 0;
    @(posedge clk);
    cmd_space <= sp;
    cmd_width <= w;
    cmd_write <= wr;
    cmd_addr  <= a;
    cmd_wdata <= d;
    cmd_valid <= 1'b1;
    do begin
      @(negedge clk);
      k++;
    end while (cmd_ready !== 1'b1 && k < 300);
    @(posedge clk);
    cmd_valid <= 1'b0;
    do begin
      @(negedge clk);
      k++;
    end while (rsp_valid !== 1'b1 && k < 340);
    if (k >= 340) begin
      n_fail++;
      $display("mismatch at %0t: no response", $time);
      wrap_up();
    end
    if (!wr) chk16(rsp_data, d);
  endtask : t

  // Strap choice is sampled while reset is held
  task automatic rst(input logic dr);
    @(posedge clk);
    rst_n    <= 1'b0;
    disk_req <= dr;
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
  endtask : rst

  initial begin
    {rst_n, disk_req, cmd_valid, cmd_write, rx_ready} = '0;
    {cmd_space, cmd_width, cmd_addr, cmd_wdata} = '0;
    tx_data = 16'hBEEF;
    n_fail = 0;
    checked = 0;
    rst(1'b0);
    chk1(c_disk, 1'b0);
    chk1(h_disk, 1'b0);
    t(3'h0, 2'h0, 0, 11'h000, 16'hFF01);
    t(3'h0, 2'h0, 0, 11'h001, 16'hFFFF);
    t(3'h0, 2'h0, 1, 11'h000, 16'h0055);
    t(3'h0, 2'h1, 0, 11'h000, 16'hFF01);
    t(3'h0, 2'h1, 1, 11'h206, 16'hAA10);
    t(3'h0, 2'h0, 0, 11'h206, 16'hFF10);
    t(3'h1, 2'h1, 1, 11'h002, 16'h5AA5);
    t(3'h1, 2'h1, 0, 11'h002, 16'h5AA5);
    t(3'h1, 2'h0, 0, 11'h003, 16'hFF5A);
    t(3'h1, 2'h2, 0, 11'h003, 16'h5AFF);
    t(3'h1, 2'h2, 1, 11'h005, 16'h3C00);
    t(3'h1, 2'h0, 0, 11'h005, 16'hFF3C);
    t(3'h0, 2'h0, 1, 11'h200, 16'h0001);
    t(3'h2, 2'h1, 0, 11'h002, 16'h5AA5);
    t(3'h2, 2'h0, 1, 11'h002, 16'h0011);
    t(3'h2, 2'h0, 0, 11'h002, 16'hFF11);
    t(3'h0, 2'h0, 1, 11'h200, 16'h0002);
    t(3'h2, 2'h0, 0, 11'h1F2, 16'hFF11);
    t(3'h2, 2'h0, 0, 11'h3F6, 16'hFF58);
    rst(1'b1);
    chk1(c_disk, 1'b1);
    chk1(h_disk, 1'b1);
    chk1(byte_mode, 1'b0);
    t(3'h0, 2'h0, 0, 11'h000, 16'hFFFF);
    t(3'h0, 2'h0, 0, 11'h200, 16'hFFFF);
    t(3'h3, 2'h0, 0, 11'h007, 16'hFF58);
    t(3'h3, 2'h0, 0, 11'h00E, 16'hFF58);
    t(3'h3, 2'h0, 1, 11'h002, 16'h7733);
    t(3'h3, 2'h0, 0, 11'h002, 16'hFF33);
    t(3'h2, 2'h1, 0, 11'h000, 16'hFFFF);
    t(3'h2, 2'h1, 1, 11'h002, 16'h9999);
    t(3'h3, 2'h0, 0, 11'h002, 16'hFF33);
    t(3'h3, 2'h1, 0, 11'h000, 16'hBEEF);
    t(3'h4, 2'h1, 0, 11'h000, 16'hBEEF);
    chk16(16'(n_ack), 16'h0002);
    // Alternate PIO and DMA pushes until the FIFO refuses
    for (i = 0; i < 16; i++) begin
      t(i[0] ? 3'h4 : 3'h3, 2'h1, 1, 11'h000, {12'h100, i[3:0]});
    end
    chk1(bus.card_ready, 1'b0);
    @(posedge clk);
    rx_ready <= 1'b1;
    for (i = 0; i < 16; i++) begin
      @(negedge clk);
      chk16(rx_data, {12'h100, i[3:0]});
    end
    @(negedge clk);
    chk1(rx_valid, 1'b0);
    @(posedge clk);
    rx_ready <= 1'b0;
    t(3'h3, 2'h0, 1, 11'h001, 16'h0001);
    t(3'h3, 2'h0, 1, 11'h007, 16'h00EF);
    chk1(byte_mode, 1'b1);
    t(3'h3, 2'h1, 1, 11'h000, 16'hABCD);
    chk16(rx_data, 16'h00CD);
    t(3'h3, 2'h0, 1, 11'h001, 16'h0081);
    t(3'h3, 2'h0, 1, 11'h007, 16'h00EF);
    chk1(byte_mode, 1'b0);
    wrap_up();
  end
endmodule : card_host_bus_access_decoder_bench

// *** verif/chb_sva.sv ***
// Link-side checks on the card's lane drivers
`timescale 1ns/1ps
module chb_sva (
  input wire logic        clk,
  input wire logic        rst_n,
  input wire logic        attr_sel_n,
  input wire logic        high_lane_select_n,
  input wire logic        low_lane_select_n,
  input wire logic [10:0] addr,
  input wire logic        out_strobe_n,
  input wire logic        write_strobe_n,
  input wire logic        io_read_strobe_n,
  input wire logic        io_write_strobe_n,
  input wire logic        dma_ack_n,
  input wire logic [15:0] card_dout,
  input wire logic [1:0]  card_doe_n
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  logic hi;
  logic lo;
  assign hi = high_lane_select_n;
  assign lo = low_lane_select_n;

  AST_NO_SELECT_FLOAT: assert property ((hi && lo && dma_ack_n)[*4]
    |-> card_doe_n == 2'b11) else $error("lanes driven with no select");
  AST_RELEASE_FLOAT: assert property ($rose(out_strobe_n && io_read_strobe_n)
    |-> ##[1:3] card_doe_n == 2'b11) else $error("lanes held after read");
  AST_WRITE_NO_DRIVE: assert property
    ((!io_write_strobe_n || !write_strobe_n)[*4] |-> card_doe_n == 2'b11)
    else $error("lanes driven during write");
  AST_ATTR_HIGH_FF: assert property
    (!attr_sel_n && !out_strobe_n && !card_doe_n[1]
     |-> card_dout[15:8] == 8'hFF) else $error("attribute high lane valid");
  AST_ODD_LOW_FLOAT: assert property
    ((attr_sel_n && !hi && lo && !out_strobe_n)[*4] |-> card_doe_n[0])
    else $error("low lane driven on odd byte read");
  AST_BYTE_HIGH_FLOAT: assert property
    ((hi && !lo && !io_read_strobe_n && addr[2:0] != 3'h0)[*4]
     |-> card_doe_n[1]) else $error("high lane driven on byte read");
  AST_WORD_BOTH: assert property
    ((attr_sel_n && !hi && !lo && !out_strobe_n)[*4]
     |-> card_doe_n == 2'b00) else $error("word read not on both lanes");
  AST_DMA_BOTH: assert property
    ((!dma_ack_n && hi && lo && !io_read_strobe_n)[*4]
     |-> card_doe_n == 2'b00) else $error("DMA read not on both lanes");
endmodule : chb_sva
